// File: test_usb_irq_ep_ctrl.sv
// Self-checking bench for the USB interrupt and endpoint control block
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) \
  begin \
    check_count++; \
    if ((got) !== (exp)) \
    begin \
      failures++; \
      $display("MISMATCH t=%0t got %0h exp %0h", $time, got, exp); \
    end \
  end

module test_usb_irq_ep_ctrl;
  localparam int unsigned IDLE_N = 50;
  localparam logic [11:0] STS    = usb_irq_ep_pkg::OFF_IRQ_STATUS;
  localparam logic [11:0] MSK    = usb_irq_ep_pkg::OFF_IRQ_MASK;
  localparam logic [11:0] MOD    = usb_irq_ep_pkg::OFF_MODE;
  logic                     clk, resetn, psel, penable, pwrite;
  logic [11:0]              paddr;
  logic [31:0]              pwdata, prdata, rd;
  logic                     pready, pslverr, err, ea;
  logic                     low_speed_link, dp_pin, dm_pin;
  logic                     host_ls_direct, host_retry_en, irq;
  logic [3:0]               stall_ep;
  usb_irq_ep_pkg::usb_evt_t evt;
  usb_irq_ep_pkg::tok_req_t tok_req;
  usb_irq_ep_pkg::tok_rsp_t tok_rsp, r;
  int                       failures, check_count, cycles;

  usb_irq_ep_ctrl #(.NUM_EP(16), .IDLE_CYCLES(IDLE_N)) dut (
    .clk(clk), .resetn(resetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .evt(evt),
    .stall_ep(stall_ep), .low_speed_link(low_speed_link),
    .dp_pin(dp_pin), .dm_pin(dm_pin), .tok_req(tok_req),
    .tok_rsp(tok_rsp), .host_ls_direct(host_ls_direct),
    .host_retry_en(host_retry_en), .irq(irq));

  usb_far_side_model far (
    .clk(clk), .evt(evt), .stall_ep(stall_ep),
    .low_speed_link(low_speed_link), .dp_pin(dp_pin), .dm_pin(dm_pin),
    .tok_req(tok_req), .tok_rsp(tok_rsp));

  // -------------------------------------------------------------
  // Clock, hang guard and closing report
  // -------------------------------------------------------------
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  initial
    cycles = 0;

  // A hang counts as a mismatch and ends the run
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      failures++;
      finish_test();
    end
  end

  task automatic finish_test();
    $display("Comparisons %0d, mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : finish_test

  // -------------------------------------------------------------
  // APB master: setup, then access held until pready is seen high
  // -------------------------------------------------------------
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] wd, output logic [31:0] q,
                     output logic e);
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge clk);
    penable <= 1'b1;
    // Answer is taken at the edge where pready is sampled high
    do
      @(posedge clk);
    while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d, rd, err);
  endtask : wr

  task automatic rchk(input logic [11:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0, rd, err);
    `CHK({err, rd}, {1'b0, x})
  endtask : rchk

  // Let registered outputs settle after a bus access
  task automatic settle();
    repeat (2) @(posedge clk);
    #1;
  endtask : settle

  function automatic logic [11:0] ep(input int n);
    return usb_irq_ep_pkg::OFF_EP_BASE + 12'(4 * n);
  endfunction : ep

  // -------------------------------------------------------------
  // Main sequence
  // -------------------------------------------------------------
  initial
  begin
    failures = 0;
    check_count = 0;
    resetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    repeat (4) @(posedge clk);
    resetn <= 1'b1;
    // Reset values, unmapped access, implemented bits
    rchk(STS, 32'h0);
    rchk(MSK, 32'h0);
    rchk(MOD, 32'h0);
    apb(1'b0, 12'h080, 32'h0, rd, err);
    `CHK({err, rd}, {1'b1, 32'h0})
    for (int n = 0; n < 16; n++)
    begin
      rchk(ep(n), 32'h0);
      wr(ep(n), 32'hFFFF_FFFD);
      rchk(ep(n), (n == 0) ? 32'hDD : 32'h1D);
      wr(ep(n), 32'h0);
    end
    wr(MSK, 32'hFF);
    rchk(MSK, 32'hBF);
    wr(MSK, 32'h0);
    // Token gating over every enable combination and token kind
    for (int i = 0; i < 16; i++)
    begin
      wr(ep(3), {27'h0, i[3], i[2], i[1], 1'b0, i[0]});
      for (int k = 0; k < 3; k++)
      begin
        far.token(4'h3, usb_irq_ep_pkg::tok_kind_t'(k), r);
        ea = (k == 0) ? i[2] : (k == 1) ? i[1] : i[2] & ~(i[1] & i[3]);
        `CHK({r.done, r.allow}, {1'b1, ea})
        if (ea)
          `CHK(r.handshake, i[0])
      end
    end
    wr(ep(3), 32'h0);
    // Stall sent: flag, endpoint status, interrupt masking, clearing
    far.pulse(5'h10, 4'h5);
    rchk(STS, 32'h80);
    rchk(ep(5), 32'h02);
    far.token(4'h5, usb_irq_ep_pkg::TOK_IN, r);
    `CHK(r.stalled, 1'b1)
    settle();
    `CHK(irq, 1'b0)
    wr(MSK, 32'h80);
    settle();
    `CHK(irq, 1'b1)
    wr(STS, 32'h7F);
    rchk(STS, 32'h80);
    wr(STS, 32'h80);
    rchk(STS, 32'h0);
    settle();
    `CHK(irq, 1'b0)
    wr(ep(5), 32'h0);
    rchk(ep(5), 32'h0);
    // Remaining event flags, each cleared by its own one
    for (int i = 0; i < 4; i++)
    begin
      far.pulse(5'(1 << i), 4'h0);
      rchk(STS, 32'(1 << i));
      wr(STS, 32'(1 << i));
    end
    rchk(STS, 32'h0);
    // Host mode: no flags, endpoint zero options drive the host outputs
    wr(MOD, 32'h1);
    far.pulse(5'h08, 4'h0);
    rchk(STS, 32'h0);
    wr(ep(0), 32'h40);
    settle();
    `CHK({host_ls_direct, host_retry_en}, 2'b00)
    wr(ep(0), 32'h80);
    settle();
    `CHK({host_ls_direct, host_retry_en}, 2'b11)
    wr(MOD, 32'h0);
    settle();
    `CHK({host_ls_direct, host_retry_en}, 2'b00)
    wr(ep(0), 32'h0);
    // Line detection: idle run, then resume signalling
    far.line(1'b1, 1'b0);
    repeat (IDLE_N - 20) @(posedge clk);
    rchk(STS, 32'h0);
    repeat (40) @(posedge clk);
    rchk(STS, 32'h10);
    wr(STS, 32'h10);
    far.line(1'b0, 1'b1);
    repeat (400) @(posedge clk);
    rchk(STS, 32'h0);
    repeat (120) @(posedge clk);
    rchk(STS, 32'h20);
    far.line(1'b0, 1'b0);
    finish_test();
  end
endmodule : test_usb_irq_ep_ctrl
`default_nettype wire

// File: usb_far_side_model.sv
// Far-side USB model: packet engine events, token queries, line states
`timescale 1ns/1ps
`default_nettype none

module usb_far_side_model (
  input  wire logic                     clk,
  output var  usb_irq_ep_pkg::usb_evt_t evt,
  output var  logic [3:0]               stall_ep,
  output var  logic                     low_speed_link,
  output var  logic                     dp_pin,
  output var  logic                     dm_pin,
  output var  usb_irq_ep_pkg::tok_req_t tok_req,
  input  wire usb_irq_ep_pkg::tok_rsp_t tok_rsp
);
  // -------------------------------------------------------------
  // Quiet bus at start: lines in single-ended zero, nothing pending
  // -------------------------------------------------------------
  initial
  begin
    evt            = '0;
    stall_ep       = 4'h0;
    low_speed_link = 1'b0;
    dp_pin         = 1'b0;
    dm_pin         = 1'b0;
    tok_req        = '0;
  end

  // One-cycle event pulse; the endpoint number scrambles afterwards
  task automatic pulse(input logic [4:0] e, input logic [3:0] ep);
    @(posedge clk);
    evt      <= usb_irq_ep_pkg::usb_evt_t'(e);
    stall_ep <= ep;
    @(posedge clk);
    evt      <= '0;
    stall_ep <= ~ep;
  endtask : pulse

  // One token query; the answer is taken in the cycle after the request
  task automatic token(input logic [3:0] ep,
                       input usb_irq_ep_pkg::tok_kind_t k,
                       output usb_irq_ep_pkg::tok_rsp_t r);
    @(posedge clk);
    tok_req <= '{valid: 1'b1, ep: ep, kind: k};
    @(posedge clk);
    tok_req <= '{valid: 1'b0, ep: ~ep, kind: usb_irq_ep_pkg::TOK_OUT};
    #1;
    r = tok_rsp;
  endtask : token

  // Drive a steady line state (full speed: J is dp high, K is dm high)
  task automatic line(input logic p, input logic m);
    @(posedge clk);
    dp_pin <= p;
    dm_pin <= m;
  endtask : line
endmodule : usb_far_side_model
`default_nettype wire

// File: usb_irq_ep_ctrl.sv
// USB device interrupt status and endpoint control registers on APB
//
// The APB interface to the registers and the register addresses were decided locally.
`timescale 1ns/1ps
`default_nettype none

module usb_irq_ep_ctrl #(
  parameter int unsigned NUM_EP      = 16,
  parameter int unsigned IDLE_CYCLES = usb_irq_ep_pkg::IDLE_CYCLES_DFLT
) (
  input  wire logic                      clk,
  input  wire logic                      resetn,
  input  wire logic [11:0]               paddr,
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [31:0]               pwdata,
  output var  logic [31:0]               prdata,
  output var  logic                      pready,
  output var  logic                      pslverr,
  input  wire usb_irq_ep_pkg::usb_evt_t  evt,
  input  wire logic [3:0]                stall_ep,
  input  wire logic                      low_speed_link,
  input  wire logic                      dp_pin,
  input  wire logic                      dm_pin,
  input  wire usb_irq_ep_pkg::tok_req_t  tok_req,
  output var  usb_irq_ep_pkg::tok_rsp_t  tok_rsp,
  output var  logic                      host_ls_direct,
  output var  logic                      host_retry_en,
  output var  logic                      irq
);

  // ---------------------------------------------------------------
  // Elaboration checks
  // ---------------------------------------------------------------
  if (NUM_EP != usb_irq_ep_pkg::MAX_EP) begin : g_bad_ep
    $error("NUM_EP must be 16");
  end
  if (IDLE_CYCLES < 2) begin : g_bad_idle
    $error("IDLE_CYCLES must be at least 2");
  end

  localparam int unsigned IDLE_W = $clog2(IDLE_CYCLES + 1);
  localparam int unsigned RES_W  = $clog2(usb_irq_ep_pkg::RESUME_CYCLES + 1);
  localparam logic [IDLE_W-1:0] IDLE_LAST = IDLE_W'(IDLE_CYCLES - 1);
  localparam logic [RES_W-1:0]  RES_LAST  =
    RES_W'(usb_irq_ep_pkg::RESUME_CYCLES - 1);

  // ---------------------------------------------------------------
  // Address decode helpers
  // ---------------------------------------------------------------
  // Endpoint window hit for a byte address
  function automatic logic is_ep_addr(input logic [11:0] a);
    logic [11:0] top;
    top = usb_irq_ep_pkg::OFF_EP_BASE
        + 12'(NUM_EP << usb_irq_ep_pkg::EP_STRIDE_LOG2);
    return (a >= usb_irq_ep_pkg::OFF_EP_BASE) && (a < top)
        && (a[1:0] == 2'h0);
  endfunction : is_ep_addr

  // Endpoint index for a byte address inside the window
  function automatic logic [3:0] ep_index(input logic [11:0] a);
    logic [11:0] rel;
    rel = a - usb_irq_ep_pkg::OFF_EP_BASE;
    return rel[5:2];
  endfunction : ep_index

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  logic [7:0]        status_q;
  logic [7:0]        status_d;
  logic [7:0]        mask_q;
  logic              host_mode_q;
  logic [7:0]        ep_q [NUM_EP];
  logic              wr_access;
  logic [7:0]        hw_set;
  logic [7:0]        rd_d;
  logic              err_d;
  logic              dp_s1_q;
  logic              dp_s2_q;
  logic              dm_s1_q;
  logic              dm_s2_q;
  logic              line_k;
  logic              line_j;
  logic [IDLE_W-1:0] idle_cnt_q;
  logic [RES_W-1:0]  res_cnt_q;
  logic              idle_hit;
  logic              res_hit;

  // Write takes effect on the access edge only
  assign wr_access = psel && penable && pready && pwrite;

  // ---------------------------------------------------------------
  // Line state sampling
  // ---------------------------------------------------------------
  // Two-flop synchronisers for the data line pins
  always_ff @(posedge clk) begin
    if (!resetn) begin
      dp_s1_q <= 1'b0;
      dp_s2_q <= 1'b0;
      dm_s1_q <= 1'b0;
      dm_s2_q <= 1'b0;
    end else begin
      dp_s1_q <= dp_pin;
      dp_s2_q <= dp_s1_q;
      dm_s1_q <= dm_pin;
      dm_s2_q <= dm_s1_q;
    end
  end

  // K and J polarity swap with link speed
  assign line_k = low_speed_link ? (dp_s2_q && !dm_s2_q)
                                 : (!dp_s2_q && dm_s2_q);
  assign line_j = low_speed_link ? (!dp_s2_q && dm_s2_q)
                                 : (dp_s2_q && !dm_s2_q);

  always_ff @(posedge clk) begin
    if (!resetn) begin
      idle_cnt_q <= '0;
    end else if (!line_j) begin
      idle_cnt_q <= '0;
    end else if (idle_cnt_q != IDLE_W'(IDLE_CYCLES)) begin
      idle_cnt_q <= idle_cnt_q + IDLE_W'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      res_cnt_q <= '0;
    end else if (!line_k) begin
      res_cnt_q <= '0;
    end else if (res_cnt_q != RES_W'(usb_irq_ep_pkg::RESUME_CYCLES)) begin
      res_cnt_q <= res_cnt_q + RES_W'(1);
    end
  end

  assign idle_hit = line_j && (idle_cnt_q == IDLE_LAST);
  assign res_hit  = line_k && (res_cnt_q == RES_LAST);

  // ---------------------------------------------------------------
  // Interrupt status
  // ---------------------------------------------------------------
  // hardware sets, suppressed in host operation
  always_comb begin
    hw_set = '0;
    hw_set[usb_irq_ep_pkg::BIT_BUS_RESET]   = evt.bus_reset;
    hw_set[usb_irq_ep_pkg::BIT_ERROR]       = evt.error_cond;
    hw_set[usb_irq_ep_pkg::BIT_FRAME_START] = evt.frame_start;
    hw_set[usb_irq_ep_pkg::BIT_TOKEN_DONE]  = evt.token_done;
    hw_set[usb_irq_ep_pkg::BIT_IDLE]        = idle_hit;
    hw_set[usb_irq_ep_pkg::BIT_RESUME]      = res_hit;
    hw_set[usb_irq_ep_pkg::BIT_STALL_SENT]  = evt.stall_sent;
    if (host_mode_q) begin
      hw_set = '0;
    end
  end

  always_comb begin
    status_d = status_q;
    if (wr_access && (paddr == usb_irq_ep_pkg::OFF_IRQ_STATUS)) begin
      status_d = status_q & ~pwdata[7:0];
    end
    status_d = (status_d | hw_set) & usb_irq_ep_pkg::IRQ_IMPL_MASK;
  end

  // Status, mask and mode storage
  always_ff @(posedge clk) begin
    if (!resetn) begin
      status_q    <= usb_irq_ep_pkg::IRQ_RESET;
      mask_q      <= 8'h00;
      host_mode_q <= 1'b0;
    end else begin
      status_q <= status_d;
      if (wr_access && (paddr == usb_irq_ep_pkg::OFF_IRQ_MASK)) begin
        mask_q <= pwdata[7:0] & usb_irq_ep_pkg::IRQ_IMPL_MASK;
      end
      if (wr_access && (paddr == usb_irq_ep_pkg::OFF_MODE)) begin
        host_mode_q <= pwdata[usb_irq_ep_pkg::MODE_HOST];
      end
    end
  end

  // Level interrupt from unmasked flags
  always_ff @(posedge clk) begin
    if (!resetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(status_d & mask_q);
    end
  end

  // ---------------------------------------------------------------
  // Endpoint control registers
  // ---------------------------------------------------------------
  // one register per endpoint
  for (genvar n = 0; n < NUM_EP; n++) begin : g_ep
    localparam logic [7:0] IMPL = (n == 0) ? usb_irq_ep_pkg::EP0_IMPL_MASK
                                           : usb_irq_ep_pkg::EPN_IMPL_MASK;
    // stall status set by hardware, wins over a write
    always_ff @(posedge clk) begin
      if (!resetn) begin
        ep_q[n] <= usb_irq_ep_pkg::EP_RESET;
      end else begin
        if (wr_access && is_ep_addr(paddr) && (ep_index(paddr) == 4'(n)))
        begin
          ep_q[n] <= pwdata[7:0] & IMPL;
        end
        if (evt.stall_sent && (stall_ep == 4'(n))) begin
          ep_q[n][usb_irq_ep_pkg::EP_STALLED] <= 1'b1;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // Token qualification for the packet engine
  // ---------------------------------------------------------------
  // direction gating and control transfer admission
  always_ff @(posedge clk) begin
    if (!resetn) begin
      tok_rsp <= '0;
    end else begin
      tok_rsp.done      <= tok_req.valid;
      tok_rsp.handshake <= 1'b0;
      tok_rsp.stalled   <= 1'b0;
      tok_rsp.allow     <= 1'b0;
      if (tok_req.valid) begin
        tok_rsp.handshake <= ep_q[tok_req.ep][usb_irq_ep_pkg::EP_HANDSHAKE];
        tok_rsp.stalled   <= ep_q[tok_req.ep][usb_irq_ep_pkg::EP_STALLED];
        case (tok_req.kind)
          usb_irq_ep_pkg::TOK_OUT:
            tok_rsp.allow <= ep_q[tok_req.ep][usb_irq_ep_pkg::EP_RX_EN];
          usb_irq_ep_pkg::TOK_IN:
            tok_rsp.allow <= ep_q[tok_req.ep][usb_irq_ep_pkg::EP_TX_EN];
          usb_irq_ep_pkg::TOK_SETUP:
            tok_rsp.allow <= ep_q[tok_req.ep][usb_irq_ep_pkg::EP_RX_EN]
              && !(ep_q[tok_req.ep][usb_irq_ep_pkg::EP_TX_EN]
                   && ep_q[tok_req.ep][usb_irq_ep_pkg::EP_CTRL_DIS]);
          default:
            tok_rsp.allow <= 1'b0;
        endcase
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      host_ls_direct <= 1'b0;
      host_retry_en  <= 1'b0;
    end else begin
      host_ls_direct <= host_mode_q
                        && ep_q[0][usb_irq_ep_pkg::EP_LS_DIRECT];
      host_retry_en  <= host_mode_q
                        && !ep_q[0][usb_irq_ep_pkg::EP_RETRY_DIS];
    end
  end

  // ---------------------------------------------------------------
  // APB slave
  // ---------------------------------------------------------------
  // read mux, absent bits read zero
  always_comb begin
    rd_d  = 8'h00;
    err_d = 1'b0;
    if (paddr == usb_irq_ep_pkg::OFF_IRQ_STATUS) begin
      rd_d = status_q;
    end else if (paddr == usb_irq_ep_pkg::OFF_IRQ_MASK) begin
      rd_d = mask_q;
    end else if (paddr == usb_irq_ep_pkg::OFF_MODE) begin
      rd_d[usb_irq_ep_pkg::MODE_HOST] = host_mode_q;
    end else if (is_ep_addr(paddr)) begin
      rd_d = ep_q[ep_index(paddr)];
    end else begin
      err_d = 1'b1;
    end
  end

  // Ready from the first cycle of the access phase, no wait states
  always_ff @(posedge clk) begin
    if (!resetn) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && err_d;
      prdata  <= (psel && !penable && !pwrite) ? {24'h000000, rd_d}
                                               : 32'h0000_0000;
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  sequence s_tok(usb_irq_ep_pkg::tok_kind_t k);
    tok_req.valid && (tok_req.kind == k);
  endsequence

  property p_idle_flag;
    (idle_hit && !host_mode_q) |=> status_q[usb_irq_ep_pkg::BIT_IDLE];
  endproperty
  a_idle_flag: assert property (p_idle_flag)
    else $error("idle flag not set after idle time");

  property p_idle_cause;
    $rose(status_q[usb_irq_ep_pkg::BIT_IDLE]) |-> $past(idle_hit);
  endproperty
  a_idle_cause: assert property (p_idle_cause)
    else $error("idle flag set without idle time");

  property p_host_quiet;
    host_mode_q |=> ((status_q & ~$past(status_q)) == 8'h00);
  endproperty
  a_host_quiet: assert property (p_host_quiet)
    else $error("status flag raised in host operation");

  property p_rx_gate;
    s_tok(usb_irq_ep_pkg::TOK_OUT) |=> tok_rsp.done
      && (tok_rsp.allow == $past(ep_q[tok_req.ep][3]));
  endproperty
  a_rx_gate: assert property (p_rx_gate)
    else $error("receive gating wrong");

  property p_tx_gate;
    s_tok(usb_irq_ep_pkg::TOK_IN) |=> tok_rsp.done
      && (tok_rsp.allow == $past(ep_q[tok_req.ep][2]));
  endproperty
  a_tx_gate: assert property (p_tx_gate)
    else $error("transmit gating wrong");

  property p_setup_gate;
    s_tok(usb_irq_ep_pkg::TOK_SETUP) ##0 (ep_q[tok_req.ep][3:2] == 2'h3)
      |=> (tok_rsp.allow == !$past(ep_q[tok_req.ep][4]));
  endproperty
  a_setup_gate: assert property (p_setup_gate)
    else $error("control disable not honoured");

  property p_stall_bit;
    evt.stall_sent |=> ep_q[$past(stall_ep)][1] ##1 1'b1;
  endproperty
  a_stall_bit: assert property (p_stall_bit)
    else $error("stall status not set");

  property p_handshake;
    tok_req.valid |=> (tok_rsp.handshake == $past(ep_q[tok_req.ep][0]));
  endproperty
  a_handshake: assert property (p_handshake)
    else $error("handshake enable not reflected");

  property p_host_opts;
    ##1 (host_ls_direct == $past(host_mode_q && ep_q[0][7]))
      && (host_retry_en == $past(host_mode_q && !ep_q[0][6]));
  endproperty
  a_host_opts: assert property (p_host_opts)
    else $error("endpoint zero host options wrong");

  property p_rd_zero;
    pready |-> (prdata[31:8] == 24'h000000)
      && !((paddr == usb_irq_ep_pkg::OFF_IRQ_STATUS) && prdata[6])
      && !(is_ep_addr(paddr) && (prdata[5]
           || ((ep_index(paddr) != 4'h0) && (prdata[7:6] != 2'h0))));
  endproperty
  a_rd_zero: assert property (p_rd_zero)
    else $error("unimplemented bits read nonzero");

  property p_w1c_keep;
    (wr_access && (paddr == usb_irq_ep_pkg::OFF_IRQ_STATUS))
      |=> ((status_q & $past(~pwdata[7:0] & status_q))
           == $past(~pwdata[7:0] & status_q));
  endproperty
  a_w1c_keep: assert property (p_w1c_keep)
    else $error("written zero cleared a flag");

  property p_stall_flag;
    (evt.stall_sent && !host_mode_q)
      |=> status_q[usb_irq_ep_pkg::BIT_STALL_SENT];
  endproperty
  a_stall_flag: assert property (p_stall_flag)
    else $error("stall-sent flag not set");

  property p_resume;
    (res_hit && !host_mode_q) |=> status_q[usb_irq_ep_pkg::BIT_RESUME];
  endproperty
  a_resume: assert property (p_resume)
    else $error("resume flag not set");

endmodule : usb_irq_ep_ctrl

`default_nettype wire

// File: usb_irq_ep_pkg.sv
// Shared constants and types for the USB interrupt and endpoint control block
package usb_irq_ep_pkg;

  // ---------------------------------------------------------------
  // Register map (byte addresses on the APB)
  // ---------------------------------------------------------------
  localparam int unsigned ADDR_W = 12;
  localparam logic [11:0] OFF_IRQ_STATUS = 12'h000;
  localparam logic [11:0] OFF_IRQ_MASK   = 12'h004;
  localparam logic [11:0] OFF_MODE       = 12'h008;
  localparam logic [11:0] OFF_EP_BASE    = 12'h040;
  localparam int unsigned EP_STRIDE_LOG2 = 2;
  localparam int unsigned MAX_EP         = 16;

  // ---------------------------------------------------------------
  // Interrupt status fields
  // ---------------------------------------------------------------
  localparam int unsigned BIT_BUS_RESET   = 0;
  localparam int unsigned BIT_ERROR       = 1;
  localparam int unsigned BIT_FRAME_START = 2;
  localparam int unsigned BIT_TOKEN_DONE  = 3;
  localparam int unsigned BIT_IDLE        = 4;
  localparam int unsigned BIT_RESUME      = 5;
  localparam int unsigned BIT_STALL_SENT  = 7;
  localparam logic [7:0]  IRQ_IMPL_MASK   = 8'hBF;
  localparam logic [7:0]  IRQ_RESET       = 8'h00;

  // ---------------------------------------------------------------
  // Endpoint control fields
  // ---------------------------------------------------------------
  localparam int unsigned EP_HANDSHAKE = 0;
  localparam int unsigned EP_STALLED   = 1;
  localparam int unsigned EP_TX_EN     = 2;
  localparam int unsigned EP_RX_EN     = 3;
  localparam int unsigned EP_CTRL_DIS  = 4;
  localparam int unsigned EP_RETRY_DIS = 6;
  localparam int unsigned EP_LS_DIRECT = 7;
  localparam logic [7:0]  EP0_IMPL_MASK = 8'hDF;
  localparam logic [7:0]  EPN_IMPL_MASK = 8'h1F;
  localparam logic [7:0]  EP_RESET      = 8'h00;
  localparam int unsigned MODE_HOST     = 0;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_MHZ        = 200;
  localparam int unsigned IDLE_TIME_MS   = 3;
  localparam int unsigned RESUME_TIME_NS = 2500;
  localparam int unsigned IDLE_CYCLES_DFLT = IDLE_TIME_MS * CLK_MHZ * 1000;
  localparam int unsigned RESUME_CYCLES =
    (RESUME_TIME_NS * CLK_MHZ + 999) / 1000;

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {TOK_OUT, TOK_IN, TOK_SETUP} tok_kind_t;

  typedef struct packed {
    logic stall_sent;
    logic token_done;
    logic frame_start;
    logic error_cond;
    logic bus_reset;
  } usb_evt_t;

  typedef struct packed {
    logic       valid;
    logic [3:0] ep;
    tok_kind_t  kind;
  } tok_req_t;

  typedef struct packed {
    logic done;
    logic allow;
    logic handshake;
    logic stalled;
  } tok_rsp_t;

endpackage : usb_irq_ep_pkg
